// file: rpsel_pkg.sv
// package for the remappable output pin select bank
package rpsel_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses on the ahb-lite bus)
    // ------------------------------------------------------------
    localparam int          NUM_REGS      = 8;
    localparam int          NUM_PINS      = 16;
    localparam int          SEL_W         = 6;
    localparam logic [11:0] ADDR_BASE     = 12'h000;
    localparam logic [11:0] ADDR_LAST     = 12'h01C;
    localparam int          IDX_LSB       = 2;
    localparam int          IDX_W         = 3;
    localparam int          HI_LSB        = 8;
    localparam int          LO_LSB        = 0;
    localparam logic [31:0] IMPL_MASK     = 32'h0000_3F3F;
    localparam logic [31:0] LO_FIELD_MASK = 32'h0000_003F;
    localparam logic [5:0]  SEL_NONE      = 6'h00;
    localparam logic [15:0] REG_RESET     = 16'h0000;
    localparam logic [2:0]  IDX_PINS_176_120 = 3'h5;
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0]  HTRANS_SEQ    = 2'h3;
    localparam logic [2:0]  HSIZE_WORD    = 3'h2;

    // ------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [IDX_W-1:0] idx;
        logic        mapped;
    } rpsel_addr_type;

    typedef struct packed {
        logic [SEL_W-1:0] hi_sel;
        logic [SEL_W-1:0] lo_sel;
    } rpsel_pair_type;
endpackage : rpsel_pkg

// file: rpsel_remap_out.sv
// remappable output pin select register bank with ahb-lite slave
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// R1: each register holds two 6-bit selects, bits 13:8 and bits 5:0.
// R2: registers five to twelve serve fixed pin pairs; upper field drives first pin.
// R3: bits 15:14 read zero, writes ignored.
// R4: bits 7:6 read zero, writes discarded.
// R5: select bits are read/write and clear to zero at reset.
// R6: registers five to eight, and nine, exist only in some variants.
// R7: lower field of register ten exists only in the largest variants.
// R8: select zero leaves the pin on its default port function.
module rpsel_remap_out #(
    parameter bit HAS_REGS_5_8  = 1'b1,   // larger pin-count variant
    parameter bit HAS_REG_9     = 1'b1,   // narrower subset variant
    parameter bit HAS_PIN120    = 1'b1    // highest pin-count variant
) (
    input  wire logic        hclk,        // system clock, 200 mhz
    input  wire logic        hresetn,     // async reset, active low
    input  wire logic        hsel,        // slave select
    input  wire logic [11:0] haddr,       // byte address
    input  wire logic [1:0]  htrans,      // transfer type
    input  wire logic        hwrite,      // write when high
    input  wire logic [2:0]  hsize,       // transfer size
    input  wire logic [31:0] hwdata,      // write data
    input  wire logic        hready,      // bus ready in
    output logic      [31:0] hrdata,      // read data, registered
    output logic             hreadyout,   // always ready
    output logic             hresp,       // always okay
    output logic [95:0]      pin_func_sel,// 16 selects, pin order see note
    output logic [15:0]      pin_remap_en // select nonzero per pin
);
    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic logic reg_present(input logic [2:0] idx);
        // registers 5..8 sit at index 0..3, register 9 at index 4
        if (idx <= 3'h3) begin
            return HAS_REGS_5_8;                                   // [R6]
        end else if (idx == 3'h4) begin
            return HAS_REG_9;                                      // [R6]
        end else begin
            return 1'b1;
        end
    endfunction : reg_present

    function automatic logic [31:0] write_mask(input logic [2:0] idx);
        if (idx == rpsel_pkg::IDX_PINS_176_120 && !HAS_PIN120) begin
            return rpsel_pkg::IMPL_MASK & ~rpsel_pkg::LO_FIELD_MASK; // [R7]
        end else begin
            return rpsel_pkg::IMPL_MASK;                           // [R3] [R4]
        end
    endfunction : write_mask

    rpsel_pkg::rpsel_addr_type aph;
    rpsel_pkg::rpsel_addr_type dph_r;
    logic [15:0]               regs_r [rpsel_pkg::NUM_REGS];
    logic                      in_range;

    always_comb begin
        in_range   = 1'b0;
        aph.valid  = 1'b0;
        aph.write  = hwrite;
        aph.idx    = haddr[rpsel_pkg::IDX_LSB +: rpsel_pkg::IDX_W];
        aph.mapped = 1'b0;
        if (haddr >= rpsel_pkg::ADDR_BASE && haddr <= rpsel_pkg::ADDR_LAST) begin
            in_range = 1'b1;
        end
        if (hsel && hready &&
            (htrans == rpsel_pkg::HTRANS_NONSEQ || htrans == rpsel_pkg::HTRANS_SEQ)) begin
            aph.valid  = 1'b1;
            aph.mapped = in_range && reg_present(aph.idx) &&
                         (haddr[1:0] == 2'b00) && (hsize == rpsel_pkg::HSIZE_WORD);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_r <= '0;
        end else begin
            dph_r <= aph;
        end
    end

    // ------------------------------------------------------------
    // select registers
    // ------------------------------------------------------------
    // write lands at the end of the data phase; unimplemented bits never store
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < rpsel_pkg::NUM_REGS; i++) begin
                regs_r[i] <= rpsel_pkg::REG_RESET;                 // [R5]
            end
        end else if (dph_r.valid && dph_r.write && dph_r.mapped) begin
            regs_r[dph_r.idx] <= 16'(hwdata & write_mask(dph_r.idx)); // [R1] [R3] [R4] [R5]
        end
    end

    // ------------------------------------------------------------
    // bus answers
    // ------------------------------------------------------------
    // read data is registered in the address phase, so it stands in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (aph.valid && !aph.write && aph.mapped) begin
            hrdata <= 32'(regs_r[aph.idx]) & write_mask(aph.idx);  // [R3] [R4] [R7]
        end else begin
            hrdata <= '0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // pin outputs
    // ------------------------------------------------------------
    // pin k = 2*reg + 0 is the upper (first) pin, 2*reg + 1 the lower
    // note: outputs lag a register write by one cycle, keeping them flop-driven
    for (genvar g = 0; g < rpsel_pkg::NUM_REGS; g++) begin : g_pins
        rpsel_pkg::rpsel_pair_type pair;
        assign pair.hi_sel = regs_r[g][rpsel_pkg::HI_LSB +: rpsel_pkg::SEL_W];
        assign pair.lo_sel = regs_r[g][rpsel_pkg::LO_LSB +: rpsel_pkg::SEL_W];
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                pin_func_sel[12*g +: 12] <= '0;
                pin_remap_en[2*g +: 2]   <= '0;
            end else begin
                pin_func_sel[12*g +: 12] <= {pair.lo_sel, pair.hi_sel};   // [R2]
                pin_remap_en[2*g]        <= pair.hi_sel != rpsel_pkg::SEL_NONE; // [R8]
                pin_remap_en[2*g+1]      <= pair.lo_sel != rpsel_pkg::SEL_NONE; // [R8]
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_wr_phase;
        dph_r.valid && dph_r.write && dph_r.mapped;
    endsequence

    property p_unimpl_zero;
        @(posedge hclk) disable iff (!hresetn)
        hrdata[15:14] == 2'b00 && hrdata[7:6] == 2'b00 && hrdata[31:16] == 16'h0000;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("reserved read bits nonzero"); // [R3]

    property p_write_stores;
        @(posedge hclk) disable iff (!hresetn)
        s_wr_phase |=> regs_r[$past(dph_r.idx)][13:8] == $past(hwdata[13:8]);
    endproperty
    a_write_stores: assert property (p_write_stores) else $error("upper select not stored"); // [R1]

    property p_reserved_low;
        @(posedge hclk) disable iff (!hresetn)
        s_wr_phase |=> regs_r[$past(dph_r.idx)][7:6] == 2'b00;
    endproperty
    a_reserved_low: assert property (p_reserved_low) else $error("bits 7:6 stored"); // [R4]

    property p_pin_follows;
        @(posedge hclk) disable iff (!hresetn)
        s_wr_phase |=> ##1 pin_func_sel[12*$past(dph_r.idx,2) +: 6] == $past(hwdata[13:8], 2);
    endproperty
    a_pin_follows: assert property (p_pin_follows) else $error("first pin not from upper field"); // [R2]

    property p_enable_zero;
        @(posedge hclk) disable iff (!hresetn)
        pin_remap_en[0] == (pin_func_sel[5:0] != 6'h00);
    endproperty
    a_enable_zero: assert property (p_enable_zero) else $error("remap enable mismatch"); // [R8]

    property p_pin120_absent;
        @(posedge hclk) disable iff (!hresetn)
        !HAS_PIN120 |-> regs_r[5][5:0] == 6'h00;
    endproperty
    a_pin120_absent: assert property (p_pin120_absent) else $error("pin120 field present"); // [R7]

    property p_absent_regs;
        @(posedge hclk) disable iff (!hresetn)
        !HAS_REGS_5_8 |-> regs_r[0] == 16'h0000 && regs_r[3] == 16'h0000;
    endproperty
    a_absent_regs: assert property (p_absent_regs) else $error("absent register written"); // [R6]

    property p_read_back;
        @(posedge hclk) disable iff (!hresetn)
        (aph.valid && !aph.write && aph.mapped) |=> hrdata[13:8] == $past(regs_r[aph.idx][13:8]);
    endproperty
    a_read_back: assert property (p_read_back) else $error("read data wrong"); // [R5]

    // ------------------------------------------------------------
    // refused accesses, lower fields and per-pin mapping
    // ------------------------------------------------------------
    sequence s_rd_phase;
        aph.valid && !aph.write && aph.mapped;
    endsequence

    sequence s_refused_wr;
        dph_r.valid && dph_r.write && !dph_r.mapped;
    endsequence

    // expectation is built from the variant flag, not from the write mask,
    // so a broken mask cannot hide behind itself
    property p_write_lower;
        @(posedge hclk) disable iff (!hresetn)
        s_wr_phase |=> regs_r[$past(dph_r.idx)][5:0] ==
            (($past(dph_r.idx) == rpsel_pkg::IDX_PINS_176_120 && !HAS_PIN120) ?
             6'h00 : $past(hwdata[5:0]));
    endproperty
    a_write_lower: assert property (p_write_lower) else $error("lower select not stored"); // [R1] [R7]

    property p_read_lower;
        @(posedge hclk) disable iff (!hresetn)
        s_rd_phase |=> hrdata[5:0] == $past(regs_r[aph.idx][5:0]);
    endproperty
    a_read_lower: assert property (p_read_lower) else $error("lower read data wrong"); // [R5]

    // any cycle that is not a mapped read leaves zero on the read bus
    property p_read_idle;
        @(posedge hclk) disable iff (!hresetn)
        !(aph.valid && !aph.write && aph.mapped) |=> hrdata == 32'h0000_0000;
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("refused read not zero"); // [R6]

    property p_ready_okay;
        @(posedge hclk) disable iff (!hresetn)
        hreadyout && !hresp;
    endproperty
    a_ready_okay: assert property (p_ready_okay) else $error("bus not ready or error"); // [R5]

    property p_mapped_word;
        @(posedge hclk) disable iff (!hresetn)
        (aph.valid && aph.mapped) |-> haddr[1:0] == 2'b00 && hsize == rpsel_pkg::HSIZE_WORD;
    endproperty
    a_mapped_word: assert property (p_mapped_word) else $error("odd access mapped"); // [R1]

    property p_absent_reg9;
        @(posedge hclk) disable iff (!hresetn)
        !HAS_REG_9 |-> regs_r[4] == 16'h0000;
    endproperty
    a_absent_reg9: assert property (p_absent_reg9) else $error("absent register 9 written"); // [R6]

    property p_absent_mid;
        @(posedge hclk) disable iff (!hresetn)
        !HAS_REGS_5_8 |-> regs_r[1] == 16'h0000 && regs_r[2] == 16'h0000;
    endproperty
    a_absent_mid: assert property (p_absent_mid) else $error("absent register written"); // [R6]

    // one copy per register: a fault in one pair must not hide behind
    // the pair that the single-slot checks above look at
    for (genvar c = 0; c < rpsel_pkg::NUM_REGS; c++) begin : g_chk
        property p_reg_reserved;
            @(posedge hclk) disable iff (!hresetn)
            regs_r[c][15:14] == 2'b00 && regs_r[c][7:6] == 2'b00;
        endproperty
        a_reg_reserved: assert property (p_reg_reserved) else $error("reserved bits stored"); // [R3] [R4]

        property p_refused_keeps;
            @(posedge hclk) disable iff (!hresetn)
            s_refused_wr |=> $stable(regs_r[c]);
        endproperty
        a_refused_keeps: assert property (p_refused_keeps) else $error("refused write stored"); // [R6]

        property p_idle_keeps;
            @(posedge hclk) disable iff (!hresetn)
            !(dph_r.valid && dph_r.write && dph_r.mapped) |=> $stable(regs_r[c]);
        endproperty
        a_idle_keeps: assert property (p_idle_keeps) else $error("register changed idle"); // [R5]

        property p_hi_pin;
            @(posedge hclk) disable iff (!hresetn)
            1'b1 |=> pin_func_sel[12*c +: 6] == $past(regs_r[c][13:8]);
        endproperty
        a_hi_pin: assert property (p_hi_pin) else $error("first pin select wrong"); // [R2]

        property p_lo_pin;
            @(posedge hclk) disable iff (!hresetn)
            1'b1 |=> pin_func_sel[12*c+6 +: 6] == $past(regs_r[c][5:0]);
        endproperty
        a_lo_pin: assert property (p_lo_pin) else $error("second pin select wrong"); // [R2]

        property p_en_pair;
            @(posedge hclk) disable iff (!hresetn)
            pin_remap_en[2*c+1] == (pin_func_sel[12*c+6 +: 6] != rpsel_pkg::SEL_NONE) &&
            pin_remap_en[2*c] == (pin_func_sel[12*c +: 6] != rpsel_pkg::SEL_NONE);
        endproperty
        a_en_pair: assert property (p_en_pair) else $error("pair enable mismatch"); // [R8]
    end
endmodule : rpsel_remap_out
`default_nettype wire

// file: rpsel_remap_out_tb.sv
// self-checking bench for the remappable output pin select bank
`timescale 1ns/100ps
`default_nettype none
module rpsel_remap_out_tb;
    logic        hclk, hresetn, hsel, hwrite, rd_pend, hreadyout, hresp;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, rnd;
    logic [95:0] pin_func_sel, exp_sel;
    logic [15:0] pin_remap_en, exp_en;
    logic [95:0] pin_func_sel_s, exp_sel_s;
    logic [15:0] pin_remap_en_s, exp_en_s;
    logic [15:0] mdl [8];
    logic [31:0] exp_q [$];
    int          fail_count, n_tests, seed;
    int          cycles = 0;

    rpsel_remap_out i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .pin_func_sel(pin_func_sel), .pin_remap_en(pin_remap_en));

    // smallest variant on the same bus: absent registers and pin120 field
    rpsel_remap_out #(.HAS_REGS_5_8(1'b0), .HAS_REG_9(1'b0), .HAS_PIN120(1'b0)) i_dut_small (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(), .hreadyout(), .hresp(),
        .pin_func_sel(pin_func_sel_s), .pin_remap_en(pin_remap_en_s));

    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : complete_run

    task automatic check(input logic [127:0] got, input logic [127:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask : check

    // ------------------------------------------------------------
    // single ahb-lite transfer; a read leaves its expectation in the queue
    // ------------------------------------------------------------
    task automatic ahb(input logic [11:0] a, input logic wr, input logic [31:0] d,
                       input logic [31:0] e);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= rpsel_pkg::HTRANS_NONSEQ;
        @(posedge hclk iff hreadyout === 1'b1);
        htrans  <= 2'h0;
        hwdata  <= d;
        rd_pend <= ~wr;
        if (!wr) exp_q.push_back(e);
        @(posedge hclk iff hreadyout === 1'b1);
        rd_pend <= 1'b0;
    endtask : ahb

    // iff and this monitor see pre-edge values, so the data edge is sampled race free
    always @(posedge hclk) begin
        if (rd_pend === 1'b1 && hreadyout === 1'b1) begin
            if (exp_q.size() == 0) check(1, 0, "read without expectation");
            else check({hresp, hrdata}, {1'b0, exp_q.pop_front()}, "read data");
        end
    end

    always @(posedge hclk) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            complete_run();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 96314;
        {hsel, hwrite, rd_pend, hresetn} = 4'h0;
        haddr = 12'h000;
        htrans = 2'h0;
        hsize = rpsel_pkg::HSIZE_WORD;
        hwdata = 32'h0000_0000;
        fail_count = 0;
        n_tests = 0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 8; i++) ahb(12'(4 * i), 1'b0, 0, 0);
        for (int i = 0; i < 8; i++) begin
            rnd = $random(seed);
            if (i == 3) rnd[5:0] = 6'h00;
            mdl[i] = rnd[15:0] & rpsel_pkg::IMPL_MASK[15:0];
            ahb(12'(4 * i), 1'b1, rnd, 0);
        end
        ahb(12'h020, 1'b1, 32'hFFFF_FFFF, 0);
        ahb(12'h020, 1'b0, 0, 0);
        ahb(12'h001, 1'b0, 0, 0);
        for (int i = 0; i < 8; i++) ahb(12'(4 * i), 1'b0, 0, {16'h0000, mdl[i]});
        repeat (2) @(posedge hclk);
        for (int i = 0; i < 8; i++) begin
            exp_sel[12 * i +: 6] = mdl[i][13:8];
            exp_sel[12 * i + 6 +: 6] = mdl[i][5:0];
            exp_en[2 * i] = |mdl[i][13:8];
            exp_en[2 * i + 1] = |mdl[i][5:0];
        end
        check(pin_func_sel, exp_sel, "pin selects");
        check(pin_remap_en, exp_en, "remap enables");
        exp_sel_s = exp_sel;
        exp_en_s = exp_en;
        exp_sel_s[59:0] = '0;
        exp_en_s[9:0] = '0;
        exp_sel_s[71:66] = '0;
        exp_en_s[11] = 1'b0;
        check(pin_func_sel_s, exp_sel_s, "small variant selects");
        check(pin_remap_en_s, exp_en_s, "small variant enables");
        // reset in mid-run must clear the whole bank again
        @(posedge hclk);
        hresetn <= 1'b0;
        @(posedge hclk);
        hresetn <= 1'b1;
        ahb(12'h014, 1'b0, 0, 0);
        check(pin_remap_en, 0, "enables after reset");
        check(pin_func_sel, 0, "selects after reset");
        repeat (2) @(posedge hclk);
        complete_run();
    end
endmodule : rpsel_remap_out_tb
`default_nettype wire
